// >>> hw/pic_pkg.sv
// Package of register offsets, field positions, vectors and timing for the interrupt controller.
package pic_pkg;
    localparam logic [7:0] ADDR_TIMER_EXTINT_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_PRIORITY_HIGH_BANK0 = 8'hb4;
    localparam logic [7:0] ADDR_PRIORITY_HIGH_BANK1 = 8'hb5;
    localparam logic [7:0] ADDR_PRIORITY_LOW_BANK0 = 8'hb8;
    localparam logic [7:0] ADDR_PRIORITY_LOW_BANK1 = 8'hb9;
    localparam logic [7:0] ADDR_GROUP4_CHANNEL_ENABLE = 8'hba;
    localparam logic [7:0] ADDR_GROUP4_REQUEST_FLAGS = 8'hd8;
    localparam logic [7:0] ADDR_EXTINT_MODE_AND_FLAGS = 8'he8;
    localparam logic [7:0] ADDR_SOURCE_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_HI = 8'ha9;
    localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'hf0;
    localparam logic [7:0] ADDR_IN_PROGRESS = 8'hf1;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Timer/ext control bit positions.
    localparam int TC_TF1 = 7;
    localparam int TC_TF0 = 5;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;
    // Mode and flag register fields.
    localparam int MF_IT4 = 6;
    localparam int MF_IT3 = 4;
    localparam int MF_IT2 = 2;
    localparam int MF_IE3 = 1;
    localparam int MF_IE2 = 0;
    // Peripheral flag register bit positions.
    localparam int PF_TF2 = 0;
    localparam int PF_TIMER2_EXTERNAL_EVENT_FLAG = 1;
    localparam int PF_RI = 2;
    localparam int PF_TI = 3;
    localparam int PF_ADC = 4;
    localparam int PF_SPI = 5;
    localparam int PF_SCM = 6;
    // Secondary enable bit for the modulator group.
    localparam int EN_PWM = 5;
    localparam int EN_ALL = 7;
    // Source indices in fixed polling order, index 0 polled first.
    localparam int NSRC = 13;
    localparam int S_EXT0 = 0;
    localparam int S_TMR0 = 1;
    localparam int S_EXT1 = 2;
    localparam int S_TMR1 = 3;
    localparam int S_SER = 4;
    localparam int S_TMR2 = 5;
    localparam int S_ADC = 6;
    localparam int S_SPI = 7;
    localparam int S_EXT2 = 8;
    localparam int S_EXT3 = 9;
    localparam int S_EXT4 = 10;
    localparam int S_PWM = 11;
    localparam int S_SCM = 12;
    localparam logic [15:0] VEC_NMI = 16'h007b;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [15:0] VEC_PWM = 16'h0063;
    localparam logic [15:0] VEC_SCM = 16'h006b;
    localparam logic [7:0] FILLER_OPCODE = 8'ha5;
    localparam logic [15:0] PROG_SIZE = 16'h4000;
    // Poll cycles and hardware call length in machine cycles.
    localparam logic [3:0] POLL_CYCLES = 4'h3;
    localparam logic [3:0] CALL_CYCLES = 4'h7;
    // Trigger field encodings.
    localparam logic [1:0] TRIG_LOW = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_RISE = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;
    typedef enum logic [1:0] {
        PIC_IDLE = 2'b00,
        PIC_WAIT = 2'b01,
        PIC_CALL = 2'b10
    } pic_state_t;
endpackage : pic_pkg

// >>> hw/pic_trigger.sv
// Trigger detector for one external interrupt input: synchroniser, edge and level detection.
`timescale 1ns/1ps
`default_nettype none
module pic_trigger (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic [1:0] mode,
    output logic level_req,
    output logic edge_evt
);
    import pic_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } pic_trig_t;
    pic_trig_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.prev = st_ff.s2;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // Edges are judged on two successive synchronised samples.
    always_comb begin
        level_req = (mode == TRIG_LOW) && !st_ff.s2;
        case (mode)
            TRIG_FALL: edge_evt = st_ff.prev && !st_ff.s2;
            TRIG_RISE: edge_evt = !st_ff.prev && st_ff.s2;
            TRIG_BOTH: edge_evt = st_ff.prev != st_ff.s2;
            default: edge_evt = 1'b0;
        endcase
    end
endmodule : pic_trigger
`default_nettype wire

// >>> hw/pic_ctrl.sv
// Prioritised interrupt controller: flags, enables, four-level priority, nesting and call sequencing.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl #(
    parameter int G4_CHANNELS = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire logic ext2_pin,
    input wire logic ext3_pin,
    input wire logic [G4_CHANNELS-1:0] group4_pin,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic timer2_event,
    input wire logic serial_rx_done,
    input wire logic serial_tx_done,
    input wire logic converter_done,
    input wire logic converter_cont_compare,
    input wire logic converter_above_compare,
    input wire logic spi_done,
    input wire logic scm_event,
    input wire logic [2:0] modulator_channel_flag,
    input wire logic [2:0] modulator_channel_int_enable,
    input wire logic fetch_cycle,
    input wire logic final_cycle,
    input wire logic reti_exec,
    input wire logic [7:0] fetch_opcode,
    input wire logic [15:0] fetch_pc,
    input wire logic [15:0] cur_pc,
    output logic call_req,
    output logic call_push,
    output logic [15:0] call_push_pc,
    output logic [15:0] call_vector,
    output logic call_busy,
    output logic [3:0] level_in_progress
);
    import pic_pkg::*;

    typedef struct packed {
        logic [7:0] timer_extint_control;
        logic [7:0] mode_flags;
        logic [7:0] g4_flags;
        logic [7:0] g4_sel;
        logic [7:0] prio_h0;
        logic [7:0] prio_h1;
        logic [7:0] prio_l0;
        logic [7:0] prio_l1;
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] pflags;
        logic [3:0] in_prog;
        logic nmi_prog;
        logic after_reti;
        pic_state_t state;
        logic [3:0] count;
        logic [3:0] sel_src;
        logic sel_nmi;
        logic [1:0] sel_lvl;
        logic [15:0] vec;
        logic [15:0] push_pc;
        logic push;
        logic issue;
        logic [7:0] rdata;
    } pic_ctrl_t;

    pic_ctrl_t st_ff, nxt_st;

    logic [3:0] lvl_req;
    logic [3:0] edge_evt;
    logic [G4_CHANNELS-1:0] g4_lvl;
    logic [G4_CHANNELS-1:0] g4_edge;
    logic [NSRC-1:0] req;
    logic [1:0] lvl [NSRC];
    logic [13:0] prio_h;
    logic [13:0] prio_l;
    logic win_any;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    logic blocked;
    logic nmi_req;
    logic [1:0] cur_top;
    logic any_prog;

    pic_trigger u_ext0 (.clk(clk), .rst_n(rst_n), .pin(ext0_pin),
        .mode({1'b0, st_ff.timer_extint_control[TC_IT0]}), .level_req(lvl_req[0]), .edge_evt(edge_evt[0]));
    pic_trigger u_ext1 (.clk(clk), .rst_n(rst_n), .pin(ext1_pin),
        .mode({1'b0, st_ff.timer_extint_control[TC_IT1]}), .level_req(lvl_req[1]), .edge_evt(edge_evt[1]));
    pic_trigger u_ext2 (.clk(clk), .rst_n(rst_n), .pin(ext2_pin),
        .mode(st_ff.mode_flags[MF_IT2+:2]), .level_req(lvl_req[2]), .edge_evt(edge_evt[2]));
    pic_trigger u_ext3 (.clk(clk), .rst_n(rst_n), .pin(ext3_pin),
        .mode(st_ff.mode_flags[MF_IT3+:2]), .level_req(lvl_req[3]), .edge_evt(edge_evt[3]));

    // One shared trigger field drives every group-four channel.
    genvar gi;
    generate
        for (gi = 0; gi < G4_CHANNELS; gi++) begin : g_g4
            pic_trigger u_g4 (.clk(clk), .rst_n(rst_n), .pin(group4_pin[gi]),
                .mode(st_ff.mode_flags[MF_IT4+:2]), .level_req(g4_lvl[gi]), .edge_evt(g4_edge[gi]));
        end
    endgenerate

    assign prio_h = {st_ff.prio_h1[6:0], st_ff.prio_h0[6:0]};
    assign prio_l = {st_ff.prio_l1[6:0], st_ff.prio_l0[6:0]};

    // Requests in polling order, each gated by its own enable and the global enable.
    always_comb begin
        req = '0;
        req[S_EXT0] = st_ff.timer_extint_control[TC_IE0] && st_ff.en0[0];
        req[S_TMR0] = st_ff.timer_extint_control[TC_TF0] && st_ff.en0[1];
        req[S_EXT1] = st_ff.timer_extint_control[TC_IE1] && st_ff.en0[2];
        req[S_TMR1] = st_ff.timer_extint_control[TC_TF1] && st_ff.en0[3];
        req[S_SER] = (st_ff.pflags[PF_RI] || st_ff.pflags[PF_TI]) && st_ff.en0[4];
        req[S_TMR2] = (st_ff.pflags[PF_TF2] || st_ff.pflags[PF_TIMER2_EXTERNAL_EVENT_FLAG]) && st_ff.en0[5];
        req[S_ADC] = st_ff.pflags[PF_ADC] && st_ff.en0[6];
        req[S_SPI] = st_ff.pflags[PF_SPI] && st_ff.en1[0];
        req[S_EXT2] = st_ff.mode_flags[MF_IE2] && st_ff.en1[1];
        req[S_EXT3] = st_ff.mode_flags[MF_IE3] && st_ff.en1[2];
        req[S_EXT4] = |(st_ff.g4_flags & st_ff.g4_sel) && st_ff.en1[3];
        req[S_PWM] = |(modulator_channel_flag & modulator_channel_int_enable) && st_ff.en1[EN_PWM];
        req[S_SCM] = st_ff.pflags[PF_SCM] && st_ff.en1[6];
        req = req & {NSRC{st_ff.en0[EN_ALL]}};
    end

    // Level of each source from its high and low bits; the priority map skips unused bit 4 of bank 1.
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            lvl[i] = {prio_h[i], prio_l[i]};
        end
        lvl[S_PWM] = {prio_h[12], prio_l[12]};
        lvl[S_SCM] = {prio_h[13], prio_l[13]};
    end

    // Highest level wins; the lowest index wins within a level.
    always_comb begin
        win_any = 1'b0;
        win_src = '0;
        win_lvl = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && (!win_any || lvl[i] >= win_lvl)) begin
                win_any = 1'b1;
                win_src = 4'(i);
                win_lvl = lvl[i];
            end
        end
    end

    always_comb begin
        any_prog = |st_ff.in_prog;
        cur_top = st_ff.in_prog[3] ? 2'h3 : st_ff.in_prog[2] ? 2'h2 : st_ff.in_prog[1] ? 2'h1 : 2'h0;
        nmi_req = fetch_cycle && ((fetch_opcode == FILLER_OPCODE) || (fetch_pc >= PROG_SIZE));
        blocked = !fetch_cycle || !final_cycle || st_ff.after_reti || st_ff.nmi_prog
            || (any_prog && win_lvl <= cur_top);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.push = 1'b0;
        nxt_st.issue = 1'b0;
        nxt_st.rdata = REG_RESET;
        // Hardware-set flags; the set wins over a software clear in the same cycle.
        if (reg_wr) begin
            case (reg_addr)
                ADDR_TIMER_EXTINT_CONTROL: nxt_st.timer_extint_control = reg_wdata;
                ADDR_EXTINT_MODE_AND_FLAGS: nxt_st.mode_flags = reg_wdata;
                ADDR_GROUP4_REQUEST_FLAGS: nxt_st.g4_flags = reg_wdata;
                ADDR_GROUP4_CHANNEL_ENABLE: nxt_st.g4_sel = reg_wdata;
                ADDR_PRIORITY_HIGH_BANK0: nxt_st.prio_h0 = reg_wdata & 8'h7f;
                ADDR_PRIORITY_HIGH_BANK1: nxt_st.prio_h1 = reg_wdata & 8'h6f;
                ADDR_PRIORITY_LOW_BANK0: nxt_st.prio_l0 = reg_wdata & 8'h7f;
                ADDR_PRIORITY_LOW_BANK1: nxt_st.prio_l1 = reg_wdata & 8'h6f;
                ADDR_SOURCE_ENABLE: nxt_st.en0 = reg_wdata;
                ADDR_SOURCE_ENABLE_HI: nxt_st.en1 = reg_wdata & 8'h6f;
                ADDR_PERIPH_FLAGS: nxt_st.pflags = reg_wdata & 8'h7f;
                default: ;
            endcase
        end
        if (timer0_overflow) nxt_st.timer_extint_control[TC_TF0] = 1'b1;
        if (timer1_overflow) nxt_st.timer_extint_control[TC_TF1] = 1'b1;
        if (timer2_overflow) nxt_st.pflags[PF_TF2] = 1'b1;
        if (timer2_event) nxt_st.pflags[PF_TIMER2_EXTERNAL_EVENT_FLAG] = 1'b1;
        if (serial_rx_done) nxt_st.pflags[PF_RI] = 1'b1;
        if (serial_tx_done) nxt_st.pflags[PF_TI] = 1'b1;
        if (converter_done && (!converter_cont_compare || converter_above_compare)) begin
            nxt_st.pflags[PF_ADC] = 1'b1;
        end
        if (spi_done) nxt_st.pflags[PF_SPI] = 1'b1;
        if (scm_event) nxt_st.pflags[PF_SCM] = 1'b1;
        // Vectoring clears only edge flags of ext 0-3 and timer 0/1 flags.
        if (st_ff.state == PIC_CALL && st_ff.count == '0 && !st_ff.sel_nmi) begin
            case (st_ff.sel_src)
                4'(S_EXT0): nxt_st.timer_extint_control[TC_IE0] = 1'b0;
                4'(S_EXT1): nxt_st.timer_extint_control[TC_IE1] = 1'b0;
                4'(S_TMR0): nxt_st.timer_extint_control[TC_TF0] = 1'b0;
                4'(S_TMR1): nxt_st.timer_extint_control[TC_TF1] = 1'b0;
                4'(S_EXT2): nxt_st.mode_flags[MF_IE2] = 1'b0;
                4'(S_EXT3): nxt_st.mode_flags[MF_IE3] = 1'b0;
                default: ;
            endcase
        end
        if (edge_evt[0]) nxt_st.timer_extint_control[TC_IE0] = 1'b1;
        if (edge_evt[1]) nxt_st.timer_extint_control[TC_IE1] = 1'b1;
        if (edge_evt[2]) nxt_st.mode_flags[MF_IE2] = 1'b1;
        if (edge_evt[3]) nxt_st.mode_flags[MF_IE3] = 1'b1;
        if (!st_ff.timer_extint_control[TC_IT0]) nxt_st.timer_extint_control[TC_IE0] = lvl_req[0];
        if (!st_ff.timer_extint_control[TC_IT1]) nxt_st.timer_extint_control[TC_IE1] = lvl_req[1];
        if (st_ff.mode_flags[MF_IT2+:2] == TRIG_LOW) nxt_st.mode_flags[MF_IE2] = lvl_req[2];
        if (st_ff.mode_flags[MF_IT3+:2] == TRIG_LOW) nxt_st.mode_flags[MF_IE3] = lvl_req[3];
        for (int c = 0; c < G4_CHANNELS; c++) begin
            if (st_ff.mode_flags[MF_IT4+:2] == TRIG_LOW) begin
                nxt_st.g4_flags[c] = g4_lvl[c];
            end else if (g4_edge[c]) begin
                nxt_st.g4_flags[c] = 1'b1;
            end
        end
        // Return handling.
        if (reti_exec) begin
            nxt_st.after_reti = 1'b1;
            if (st_ff.nmi_prog) begin
                nxt_st.nmi_prog = 1'b0;
            end else begin
                nxt_st.in_prog[cur_top] = 1'b0;
            end
        end else if (fetch_cycle && final_cycle) begin
            nxt_st.after_reti = 1'b0;
        end
        case (st_ff.state)
            PIC_IDLE: begin
                if (nmi_req && !st_ff.nmi_prog) begin
                    nxt_st.state = PIC_CALL;
                    nxt_st.sel_nmi = 1'b1;
                    nxt_st.count = CALL_CYCLES - 4'h1;
                end else if (win_any && !blocked) begin
                    nxt_st.state = PIC_WAIT;
                    nxt_st.sel_nmi = 1'b0;
                    nxt_st.sel_src = win_src;
                    nxt_st.sel_lvl = win_lvl;
                    nxt_st.count = POLL_CYCLES - 4'h2;
                end
            end
            PIC_WAIT: begin
                if (!req[st_ff.sel_src]) begin
                    nxt_st.state = PIC_IDLE;
                end else if (st_ff.count == '0) begin
                    nxt_st.state = PIC_CALL;
                    nxt_st.count = CALL_CYCLES - 4'h1;
                end else begin
                    nxt_st.count = st_ff.count - 4'h1;
                end
            end
            PIC_CALL: begin
                if (st_ff.count == CALL_CYCLES - 4'h1) begin
                    nxt_st.push = !st_ff.sel_nmi;
                    nxt_st.push_pc = cur_pc;
                    nxt_st.issue = 1'b1;
                    if (st_ff.sel_nmi) begin
                        nxt_st.vec = VEC_NMI;
                        nxt_st.nmi_prog = 1'b1;
                    end else begin
                        nxt_st.in_prog[st_ff.sel_lvl] = 1'b1;
                        nxt_st.vec = (st_ff.sel_src == 4'(S_PWM)) ? VEC_PWM
                            : (st_ff.sel_src == 4'(S_SCM)) ? VEC_SCM
                            : 16'(VEC_BASE + VEC_STEP * 16'(st_ff.sel_src));
                    end
                end
                if (st_ff.count == '0) begin
                    nxt_st.state = PIC_IDLE;
                end else begin
                    nxt_st.count = st_ff.count - 4'h1;
                end
            end
            default: nxt_st.state = PIC_IDLE;
        endcase
        if (reg_rd) begin
            case (reg_addr)
                ADDR_TIMER_EXTINT_CONTROL: nxt_st.rdata = st_ff.timer_extint_control;
                ADDR_EXTINT_MODE_AND_FLAGS: nxt_st.rdata = st_ff.mode_flags;
                ADDR_GROUP4_REQUEST_FLAGS: nxt_st.rdata = st_ff.g4_flags;
                ADDR_GROUP4_CHANNEL_ENABLE: nxt_st.rdata = st_ff.g4_sel;
                ADDR_PRIORITY_HIGH_BANK0: nxt_st.rdata = st_ff.prio_h0;
                ADDR_PRIORITY_HIGH_BANK1: nxt_st.rdata = st_ff.prio_h1;
                ADDR_PRIORITY_LOW_BANK0: nxt_st.rdata = st_ff.prio_l0;
                ADDR_PRIORITY_LOW_BANK1: nxt_st.rdata = st_ff.prio_l1;
                ADDR_SOURCE_ENABLE: nxt_st.rdata = st_ff.en0;
                ADDR_SOURCE_ENABLE_HI: nxt_st.rdata = st_ff.en1;
                ADDR_PERIPH_FLAGS: nxt_st.rdata = st_ff.pflags;
                ADDR_IN_PROGRESS: nxt_st.rdata = {3'h0, st_ff.nmi_prog, st_ff.in_prog};
                default: nxt_st.rdata = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign call_req = st_ff.issue;
    assign call_push = st_ff.push;
    assign call_push_pc = st_ff.push_pc;
    assign call_vector = st_ff.vec;
    assign call_busy = (st_ff.state != PIC_IDLE);
    assign level_in_progress = st_ff.in_prog;
endmodule : pic_ctrl
`default_nettype wire

// >>> verification/pic_ctrl_properties.sv
// Concurrent checks on call sequencing, vectors and in-progress levels.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_properties
    import pic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reti_exec,
    input wire logic call_req,
    input wire logic call_push,
    input wire logic [15:0] call_vector,
    input wire logic [15:0] call_push_pc,
    input wire logic [15:0] cur_pc,
    input wire logic call_busy,
    input wire logic [3:0] level_in_progress
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_call_tail;
        call_busy [*6] ##1 !call_busy;
    endsequence
    AST_CALL_ONE_CYCLE: assert property (call_req |=> !call_req)
        else $error("call request longer than one cycle");
    AST_PUSH_WITH_CALL: assert property (call_push |-> call_req)
        else $error("push without call");
    AST_CALL_AFTER_POLL: assert property (call_push |-> $past(call_busy, 3) && !$past(call_busy, 4))
        else $error("call not three cycles after poll");
    AST_CALL_LENGTH: assert property (call_push |-> s_call_tail)
        else $error("call sequence length wrong");
    AST_VECTOR_HELD: assert property (!call_req |-> $stable(call_vector))
        else $error("vector moved without call");
    AST_VECTOR_LEGAL: assert property (call_push |-> call_vector[2:0] == 3'h3 && call_vector <= VEC_SCM
        && call_vector != 16'h005b)
        else $error("illegal vector");
    AST_PUSH_PC: assert property (call_push |-> call_push_pc == $past(cur_pc))
        else $error("pushed address is not the program counter");
    AST_NMI_NO_PUSH: assert property (call_req && !call_push |-> call_vector == VEC_NMI)
        else $error("unpushed call not to fixed vector");
    AST_LEVEL_MARKED: assert property (call_push |-> level_in_progress != 4'h0)
        else $error("no level marked at call");
    AST_LEVEL_KEPT: assert property (!call_req && !$past(reti_exec) |-> $stable(level_in_progress))
        else $error("level changed without call or return");
endmodule : pic_ctrl_properties
bind pic_ctrl pic_ctrl_properties u_props (.clk(clk), .rst_n(rst_n), .reti_exec(reti_exec), .call_req(call_req),
    .call_push(call_push), .call_vector(call_vector), .call_push_pc(call_push_pc), .cur_pc(cur_pc),
    .call_busy(call_busy), .level_in_progress(level_in_progress));
`default_nettype wire

// >>> verification/pic_core_model.sv
// Behavioural core sequencer giving instruction boundaries, returns and fetched bytes.
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic do_reti,
    input wire logic bad_op,
    output logic fetch_cycle,
    output logic final_cycle,
    output logic reti_exec,
    output logic [7:0] fetch_opcode,
    output logic [15:0] fetch_pc,
    output logic [15:0] cur_pc
);
    logic [1:0] left_ff;
    assign fetch_cycle = 1'b1;
    assign final_cycle = (left_ff == 2'h0);
    assign fetch_opcode = bad_op ? pic_pkg::FILLER_OPCODE : 8'h00;
    assign fetch_pc = cur_pc;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left_ff <= 2'h0;
            cur_pc <= 16'h0100;
            reti_exec <= 1'b0;
        end else begin
            // A return never issues in the cycle after a return, so with slow clear one plain instruction runs between.
            reti_exec <= do_reti && final_cycle && !reti_exec;
            left_ff <= final_cycle ? (slow ? 2'h3 : 2'h0) : left_ff - 2'h1;
            cur_pc <= final_cycle ? cur_pc + 16'h0001 : cur_pc;
        end
    end
endmodule : pic_core_model
`default_nettype wire

// >>> verification/pic_ctrl_bench.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_bench;
    logic clk = 0, rst_n = 0, rd_s = 0, wr_s = 0, slow = 0, do_reti = 0, bad_op = 0;
    logic [7:0] addr = 0, wdat = 0, rdata, fop;
    logic [11:0] pins = '1;
    logic [16:0] p = '0;
    logic fc, fin, reti_exec, call_req, call_push, call_busy;
    logic [15:0] fpc, cpc, cvec, d, r;
    logic [3:0] lvl;
    logic [7:0] ad [9] = '{8'h88, 8'hb4, 8'hb5, 8'hb8, 8'hb9, 8'hba, 8'hd8, 8'he8, 8'h00};
    int fail_count = 0, check_count = 0, calls = 0, cyc = 0, k, n;
    always #4 clk = ~clk;
    pic_core_model core (.clk(clk), .rst_n(rst_n), .slow(slow), .do_reti(do_reti), .bad_op(bad_op),
        .fetch_cycle(fc), .final_cycle(fin), .reti_exec(reti_exec), .fetch_opcode(fop), .fetch_pc(fpc), .cur_pc(cpc));
    pic_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdat), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdata), .ext0_pin(pins[0]), .ext1_pin(pins[1]), .ext2_pin(pins[2]), .ext3_pin(pins[3]),
        .group4_pin(pins[11:4]), .timer0_overflow(p[0]), .timer1_overflow(p[1]), .timer2_overflow(p[2]),
        .timer2_event(p[3]), .serial_rx_done(p[4]), .serial_tx_done(p[5]), .converter_done(p[6]), .spi_done(p[7]),
        .scm_event(p[8]), .converter_cont_compare(p[9]), .converter_above_compare(p[10]),
        .modulator_channel_flag(p[13:11]), .modulator_channel_int_enable(p[16:14]), .fetch_cycle(fc),
        .final_cycle(fin), .reti_exec(reti_exec), .fetch_opcode(fop), .fetch_pc(fpc), .cur_pc(cpc),
        .call_req(call_req), .call_push(call_push), .call_push_pc(), .call_vector(cvec), .call_busy(call_busy),
        .level_in_progress(lvl));
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) begin addr <= a; wdat <= v; wr_s <= 1; end
        @(posedge clk) wr_s <= 0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk) begin addr <= a; rd_s <= 1; end
        @(posedge clk) rd_s <= 0;
        #1 v = {8'h00, rdata};
    endtask : rd
    task wc(input logic [15:0] v, input logic pu);
        int i;
        i = 0;
        do begin @(posedge clk); #1; i++; end while (call_req !== 1'b1 && i < 200);
        chk("call", {15'h0, call_req}, 16'h1);
        chk("vector", cvec, v);
        chk("push", {15'h0, call_push}, {15'h0, pu});
        repeat (8) @(posedge clk);
    endtask : wc
    task ret;
        int i;
        i = 0;
        @(posedge clk) do_reti <= 1;
        do begin @(posedge clk); #1; i++; end while (reti_exec !== 1'b1 && i < 50);
        @(posedge clk) begin do_reti <= 0; slow <= 1'($urandom); end
        repeat (3) @(posedge clk);
    endtask : ret
    task fall(input int b);
        @(posedge clk) pins[b] <= 0;
        repeat (3) @(posedge clk);
        pins[b] <= 1;
    endtask : fall
    always @(posedge clk) begin
        cyc++;
        if (call_req === 1'b1) calls++;
        if (cyc == 20000) begin fail_count++; finish_test(); end
    end
    initial begin
        r = 16'($urandom(32'h8f32));
        repeat (10) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        foreach (ad[i]) begin rd(ad[i], d); chk("reset", d, 16'h0); end
        wr(8'hb9, r[7:0] & 8'h6f); rd(8'hb9, d); chk("prio", d, r & 16'h006f);
        @(posedge clk) p <= 17'h001fc;
        @(posedge clk) p <= '0;
        rd(8'hf0, d); chk("pflags", d, 16'h007f);
        wr(8'hf0, 8'h00); rd(8'hf0, d); chk("pclear", d, 16'h0);
        @(posedge clk) p <= 17'h00240;
        @(posedge clk) p <= 17'h00640;
        @(posedge clk) p <= '0;
        rd(8'hf0, d); chk("cmp", d, 16'h0010);
        wr(8'hf0, 8'h00);
        for (int m = 1; m < 4; m++) begin
            wr(8'he8, 8'(m << 2)); fall(2); rd(8'he8, d);
            chk("fall", {15'h0, d[0]}, {15'h0, m != 2});
            @(posedge clk) pins[2] <= 0; repeat (4) @(posedge clk);
            wr(8'he8, 8'(m << 2)); pins[2] <= 1; repeat (4) @(posedge clk);
            rd(8'he8, d); chk("rise", {15'h0, d[0]}, {15'h0, m != 1});
        end
        wr(8'h88, 8'h01); wr(8'ha8, 8'h81); fall(0);
        wc(16'h0003, 1); chk("lvl", {12'h0, lvl}, 16'h1);
        rd(8'h88, d); chk("ie0", d, 16'h0001);
        ret(); chk("reti", {12'h0, lvl}, 16'h0);
        wr(8'h88, 8'h00); @(posedge clk) pins[0] <= 0;
        wc(16'h0003, 1); @(posedge clk) pins[0] <= 1; repeat (4) @(posedge clk);
        rd(8'h88, d); chk("lvlflag", d, 16'h0);
        ret(); wr(8'hb4, 8'h08); wr(8'hb8, 8'h08); wr(8'ha8, 8'h8a);
        @(posedge clk) p <= 17'h3;
        @(posedge clk) p <= '0;
        wc(16'h001b, 1); n = calls; repeat (60) @(posedge clk);
        chk("nest", 16'(calls), 16'(n));
        ret(); wc(16'h000b, 1); rd(8'h88, d); chk("tf", d, 16'h0);
        ret(); k = $urandom % 8;
        wr(8'hba, 8'(1 << k)); wr(8'he8, 8'h40); wr(8'ha9, 8'h08); wr(8'ha8, 8'h80);
        fall(4 + (k + 1) % 8); n = calls; repeat (30) @(posedge clk);
        chk("gate", 16'(calls), 16'(n));
        fall(4 + k); wc(16'h0053, 1);
        rd(8'hd8, d); chk("g4keep", {15'h0, d[k]}, 16'h1);
        wr(8'hd8, 8'h00); rd(8'hd8, d); chk("g4clr", d, 16'h0);
        ret(); wr(8'ha9, 8'h20); @(posedge clk) p <= 17'h00800; n = calls; repeat (30) @(posedge clk);
        chk("pwmgate", 16'(calls), 16'(n));
        p <= 17'h04800; wc(16'h0063, 1); p <= '0;
        ret(); @(posedge clk) slow <= 0; repeat (4) @(posedge clk);
        bad_op <= 1; @(posedge clk) bad_op <= 0;
        wc(16'h007b, 0);
        ret();
        finish_test();
    end
endmodule : pic_ctrl_bench
`default_nettype wire
